// [dec_regs_pkg.sv]
// register map and field layout of the decoder register bank
// assumes an 8-bit special function register port on the processor core
`default_nettype none
package dec_regs_pkg;
   localparam logic [7:0] CTRL_ADDR      = 8'hAA;
   localparam logic [7:0] DATA_ADDR      = 8'hAC;
   localparam logic [7:0] STAT_ADDR      = 8'hC8;
   localparam logic [7:0] CTRL_RESET     = 8'h3F;
   localparam logic [7:0] STAT_RESET     = 8'h01;
   localparam int         CTL_EN_BIT     = 7;
   localparam int         CTL_BASS_BIT   = 6;
   localparam int         CTL_CRCH_BIT   = 5;
   localparam int         ST_ANC_BIT     = 7;
   localparam int         ST_REQ_BIT     = 6;
   localparam int         ST_LAY_BIT     = 5;
   localparam int         ST_SYN_BIT     = 4;
   localparam int         ST_CRC_BIT     = 3;
   localparam int         ST_FS_LSB      = 1;
   localparam int         ST_VER_BIT     = 0;
   localparam logic [1:0] FS_RESERVED    = 2'h3;
   localparam int         NUM_SRC        = 5;
   localparam int         ANC_DEPTH      = 8;
   localparam int         ANC_AW         = 3;
   typedef enum logic [1:0] {
      FR_IDLE   = 2'b00,
      FR_RUN    = 2'b01,
      FR_REJECT = 2'b10
   } frame_state_t;
endpackage : dec_regs_pkg
`default_nettype wire

// [anc_buffer.sv]
// small ancillary byte buffer with registered read data
// assumes push and pop on ref_clk; pop on empty is ignored
`default_nettype none
module anc_buffer
   import dec_regs_pkg::*;
#(
   parameter int DEPTH = ANC_DEPTH,
   parameter int AW    = ANC_AW
) (
   input  wire logic       ref_clk,
   input  wire logic       arst_n,
   input  wire logic       push,
   input  wire logic [7:0] push_data,
   input  wire logic       pop,
   output var  logic [7:0] rd_data_q,
   output var  logic       not_empty_q
);
   logic [7:0]  mem [DEPTH];
   logic [AW:0] wr_q;
   logic [AW:0] rd_q;
   logic [AW:0] cnt_d;
   wire         full     = (wr_q - rd_q) == (AW+1)'(DEPTH);
   wire         do_push  = push && !full;
   wire         do_pop   = pop && (wr_q != rd_q);
   // low AW bits address the array, so depth must be a power of two
   wire [AW:0]  rd_nx    = rd_q + (AW+1)'(do_pop);
   assign cnt_d = (wr_q + (AW+1)'(do_push)) - rd_nx;

   always_ff @(posedge ref_clk) begin
      if (do_push) mem[wr_q[AW-1:0]] <= push_data;
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_q        <= '0;
         rd_q        <= '0;
         rd_data_q   <= 8'h00;
         not_empty_q <= 1'b0;
      end else begin
         wr_q        <= wr_q + (AW+1)'(do_push);
         rd_q        <= rd_nx;
         rd_data_q   <= mem[rd_nx[AW-1:0]];
         not_empty_q <= cnt_d != '0;
      end
   end
endmodule : anc_buffer
`default_nettype wire

// [audio_decoder_ctrl_regs.sv]
// control, status and bitstream data registers of the frame decoder
// assumes the core's sfr port on ref_clk; decoder events are same-clock
// How it works
// - control register at 0xAA, eight fields
// - control resets to 0x3F, masks set
// - bit2 masks layer error interrupt
// - bit1 masks sync error interrupt
// - read-only status register at 0xC8
// - ancillary flag set when buffer holds data
// - ancillary flag clears only on empty buffer
// - crc flag set on crc mismatch
// - status read clears four event flags
// - status resets to 0x01
// - bits 2:1 give sampling code
// - data register 0xAC feeds decoder input
// - version and code map to sample rates
// - sync error when no sync pattern
// - crc bit selects play or reject
// - five maskable sources, gated by enables
`default_nettype none
module audio_decoder_ctrl_regs
   import dec_regs_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       arst_n,
   input  wire logic [7:0] sfr_addr,
   input  wire logic [7:0] sfr_wdata,
   input  wire logic       sfr_wr,
   input  wire logic       sfr_rd,
   output var  logic [7:0] sfr_rdata_q,
   input  wire logic       dec_irq_en,
   input  wire logic       global_irq_en,
   input  wire logic       frame_start,
   input  wire logic       frame_end,
   input  wire logic       hdr_valid,
   input  wire logic       hdr_version,
   input  wire logic [1:0] hdr_sampling,
   input  wire logic       crc_bad,
   input  wire logic       sync_missing,
   input  wire logic       layer_bad,
   input  wire logic       need_data,
   input  wire logic       anc_push,
   input  wire logic [7:0] anc_byte,
   input  wire logic       anc_pop,
   output var  logic [7:0] anc_data_q,
   output var  logic [7:0] bitstream_byte_q,
   output var  logic       bitstream_valid_q,
   output var  logic       decoder_enable_q,
   output var  logic       bass_boost_enable_q,
   output var  logic       frame_play_q,
   output var  logic [2:0] rate_sel_q,
   output var  logic       dec_irq_q
);
   logic [7:0]   decoder_control_q;
   logic         data_request_flag_q;
   logic         layer_error_flag_q;
   logic         sync_error_flag_q;
   logic         crc_error_flag_q;
   logic [1:0]   sampling_code_q;
   logic         format_version_q;
   logic         ancillary_available;
   frame_state_t fr_q;
   frame_state_t fr_d;

   // decode of the special function register port
   wire ctrl_wr  = sfr_wr && (sfr_addr == CTRL_ADDR);
   wire data_wr  = sfr_wr && (sfr_addr == DATA_ADDR);
   wire stat_rd  = sfr_rd && (sfr_addr == STAT_ADDR);
   wire ctrl_rd  = sfr_rd && (sfr_addr == CTRL_ADDR);
   wire en       = decoder_control_q[CTL_EN_BIT];
   wire crc_play = decoder_control_q[CTL_CRCH_BIT];

   // events only count while the decoder runs
   wire ev_req = en && need_data;
   wire ev_lay = en && layer_bad;
   wire ev_syn = en && sync_missing;
   wire ev_crc = en && crc_bad;

   wire [7:0] status_word = {ancillary_available, data_request_flag_q,
                             layer_error_flag_q, sync_error_flag_q,
                             crc_error_flag_q, sampling_code_q,
                             format_version_q};

   // mask bits 4..0 line up with status bits 7..3
   wire [NUM_SRC-1:0] src_flags = status_word[7:3];
   wire [NUM_SRC-1:0] src_masks = decoder_control_q[NUM_SRC-1:0];
   wire               any_src   = |(src_flags & ~src_masks);
   wire               irq_d     = any_src && dec_irq_en && global_irq_en;

   wire [7:0] rdata_d = stat_rd ? status_word :
                        ctrl_rd ? decoder_control_q : 8'h00;

   // reserved code 11 selects no rate
   wire [2:0] rate_d = (sampling_code_q == FS_RESERVED) ? 3'h7 :
                       {format_version_q, sampling_code_q};

   anc_buffer #(
      .DEPTH (ANC_DEPTH),
      .AW    (ANC_AW)
   ) u_anc (
      .ref_clk     (ref_clk),
      .arst_n      (arst_n),
      .push        (anc_push && en),
      .push_data   (anc_byte),
      .pop         (anc_pop),
      .rd_data_q   (anc_data_q),
      .not_empty_q (ancillary_available)
   );

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) decoder_control_q <= CTRL_RESET;
      else if (ctrl_wr) decoder_control_q <= sfr_wdata;
   end

   // one read-clear cell per event flag; set wins over the read clear
   wire [3:0] ev_vec = {ev_req, ev_lay, ev_syn, ev_crc};
   wire [3:0] rc_flag;
   for (genvar g = 0; g < 4; g++) begin : g_rc_flag
      logic flag_q;
      always_ff @(posedge ref_clk or negedge arst_n) begin
         if (!arst_n) flag_q <= STAT_RESET[ST_CRC_BIT + g];
         else flag_q <= ev_vec[g] | (flag_q & ~stat_rd);
      end
      assign rc_flag[g] = flag_q;
   end
   assign {data_request_flag_q, layer_error_flag_q, sync_error_flag_q,
           crc_error_flag_q} = rc_flag;

   // header format is not touched by a status read
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         sampling_code_q  <= STAT_RESET[ST_FS_LSB +: 2];
         format_version_q <= STAT_RESET[ST_VER_BIT];
      end else if (hdr_valid && en) begin
         sampling_code_q  <= hdr_sampling;
         format_version_q <= hdr_version;
      end
   end

   // frame play or reject on crc failure
   always_comb begin
      fr_d = fr_q;
      case (fr_q)
         FR_IDLE:   if (en && frame_start) fr_d = FR_RUN;
         FR_RUN: begin
            if (!en || frame_end) fr_d = FR_IDLE;
            else if (crc_bad && !crc_play) fr_d = FR_REJECT;
         end
         FR_REJECT: if (!en || frame_end) fr_d = FR_IDLE;
         default:   fr_d = FR_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) fr_q <= FR_IDLE;
      else fr_q <= fr_d;
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         sfr_rdata_q         <= 8'h00;
         bitstream_byte_q    <= 8'h00;
         bitstream_valid_q   <= 1'b0;
         decoder_enable_q    <= 1'b0;
         bass_boost_enable_q <= 1'b0;
         frame_play_q        <= 1'b0;
         rate_sel_q          <= 3'h4;
         dec_irq_q           <= 1'b0;
      end else begin
         sfr_rdata_q         <= rdata_d;
         bitstream_valid_q   <= data_wr;
         if (data_wr) bitstream_byte_q <= sfr_wdata;
         decoder_enable_q    <= en;
         bass_boost_enable_q <= decoder_control_q[CTL_BASS_BIT];
         frame_play_q        <= (fr_d == FR_RUN);
         rate_sel_q          <= rate_d;
         dec_irq_q           <= irq_d;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   a_ctrl_write: assert property (
      ctrl_wr |=> decoder_control_q == $past(sfr_wdata))
      else $error("control write not stored");
   a_read_clears: assert property (
      stat_rd && !ev_crc && !ev_syn && !ev_lay && !ev_req
      |=> !crc_error_flag_q && !sync_error_flag_q &&
          !layer_error_flag_q && !data_request_flag_q)
      else $error("status read did not clear flags");
   a_set_wins: assert property (
      stat_rd && ev_crc |=> crc_error_flag_q)
      else $error("crc event lost on read");
   a_anc_sticky: assert property (
      ancillary_available && !anc_pop && stat_rd |=> ancillary_available)
      else $error("ancillary flag cleared by read");
   a_lay_masked: assert property (
      decoder_control_q[2] && (src_flags & ~src_masks & 5'h1B) == 5'h00
      |=> !dec_irq_q)
      else $error("masked layer error raised interrupt");
   a_syn_irq: assert property (
      sync_error_flag_q && !decoder_control_q[1] && dec_irq_en &&
      global_irq_en |=> dec_irq_q)
      else $error("unmasked sync error no interrupt");
   a_fmt_hold: assert property (
      !(hdr_valid && en)
      |=> $stable(sampling_code_q) && $stable(format_version_q))
      else $error("format bits changed without header");
   a_data_pass: assert property (
      data_wr |=> bitstream_valid_q && bitstream_byte_q == $past(sfr_wdata))
      else $error("bitstream byte not passed");
   a_reject: assert property (
      fr_q == FR_RUN && en && !frame_end && crc_bad && !crc_play
      |=> !frame_play_q && fr_q == FR_REJECT)
      else $error("bad crc frame not rejected");
   a_disabled: assert property (
      !en |=> !data_request_flag_q || $past(data_request_flag_q))
      else $error("request raised while disabled");
   a_lay_irq: assert property (
      layer_error_flag_q && !decoder_control_q[2] && dec_irq_en &&
      global_irq_en |=> dec_irq_q)
      else $error("unmasked layer error no interrupt");
   a_crc_set: assert property (
      en && crc_bad
      |=> crc_error_flag_q)
      else $error("crc event did not set flag");
   a_syn_set: assert property (
      en && sync_missing
      |=> sync_error_flag_q)
      else $error("missing sync did not set flag");
   a_lay_set: assert property (
      en && layer_bad
      |=> layer_error_flag_q)
      else $error("layer event did not set flag");
   a_anc_set: assert property (
      anc_push && en && !anc_pop
      |=> ancillary_available)
      else $error("ancillary flag not set by push");
   a_anc_keep: assert property (
      ancillary_available && !anc_pop
      |=> ancillary_available)
      else $error("ancillary flag cleared while data held");
   a_stat_read: assert property (
      stat_rd
      |=> sfr_rdata_q == $past(status_word))
      else $error("status read returned wrong value");
   a_unmapped_rd: assert property (
      !stat_rd && !ctrl_rd
      |=> sfr_rdata_q == 8'h00)
      else $error("unmapped read not zero");
   a_ctrl_rd: assert property (
      ctrl_rd
      |=> sfr_rdata_q == $past(decoder_control_q))
      else $error("control read returned wrong value");
   a_ctrl_hold: assert property (
      !ctrl_wr
      |=> $stable(decoder_control_q))
      else $error("control changed without write");
   a_hdr_take: assert property (
      hdr_valid && en
      |=> sampling_code_q == $past(hdr_sampling) &&
          format_version_q == $past(hdr_version))
      else $error("header format not taken");
   a_rate_rsvd: assert property (
      sampling_code_q == FS_RESERVED
      |=> rate_sel_q == 3'h7)
      else $error("reserved code gave a rate");
   a_irq_gate: assert property (
      !dec_irq_en || !global_irq_en
      |=> !dec_irq_q)
      else $error("interrupt passed a closed enable");
   a_irq_quiet: assert property (
      (src_flags & ~src_masks) == 5'h00
      |=> !dec_irq_q)
      else $error("interrupt with no unmasked flag");
   a_irq_raise: assert property (
      (src_flags & ~src_masks) != 5'h00 && dec_irq_en && global_irq_en
      |=> dec_irq_q)
      else $error("unmasked flag gave no interrupt");
   a_en_mirror: assert property (
      decoder_enable_q == $past(en))
      else $error("enable output does not follow control");
   a_bass_mirror: assert property (
      bass_boost_enable_q == $past(decoder_control_q[CTL_BASS_BIT]))
      else $error("bass output does not follow control");
   a_play_off: assert property (
      !en
      |=> !frame_play_q)
      else $error("frame played while disabled");
   a_anc_off: assert property (
      !ancillary_available && !en
      |=> !ancillary_available)
      else $error("ancillary pushed while disabled");
   a_crc_play: assert property (
      fr_q == FR_RUN && en && !frame_end && crc_play
      |=> frame_play_q)
      else $error("frame with crc error not played");
   a_data_quiet: assert property (
      !data_wr
      |=> !bitstream_valid_q)
      else $error("bitstream strobe without write");

   c_irq: cover property (dec_irq_q);
   c_reject: cover property (fr_q == FR_REJECT);
   c_anc: cover property (ancillary_available ##1 !ancillary_available);
   c_read_set: cover property (stat_rd && ev_req);
   c_hdr_rsvd: cover property (sampling_code_q == FS_RESERVED);
endmodule : audio_decoder_ctrl_regs
`default_nettype wire

// [dec_far_model.sv]
// far-side decoder model: replays event pulses into the register bank
// assumes requests change at negedge; each lands one negedge later
`default_nettype none
module dec_far_model (
   input  wire logic       ref_clk,
   input  wire logic [7:0] ev_req,
   output wire logic       crc_bad,
   output wire logic       sync_missing,
   output wire logic       layer_bad,
   output wire logic       need_data,
   output wire logic       anc_push,
   output wire logic       frame_start,
   output wire logic       frame_end,
   output wire logic       hdr_valid
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] pulse_q = 8'h00;
   // launched off the sampling edge so the bank never sees a race
   always @(negedge ref_clk) begin
      pulse_q <= ev_req;
   end
   assign {hdr_valid, frame_end, frame_start, anc_push} = pulse_q[7:4];
   assign {need_data, layer_bad, sync_missing, crc_bad} = pulse_q[3:0];
endmodule : dec_far_model
`default_nettype wire

// [tb_top.sv]
// self-checking bench for the decoder register bank
// assumes the far-side model drives decoder events; sfr driven here
`default_nettype none
module tb_top import dec_regs_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic       ref_clk = 1'b0, arst_n = 1'b0, sfr_wr = 1'b0;
   logic       sfr_rd = 1'b0, gie = 1'b1, hdr_version = 1'b0, dec_ie = 1'b1;
   logic       anc_pop = 1'b0;
   logic [1:0] hdr_sampling = 2'h0;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, ev_req = 8'h00;
   logic [7:0] anc_byte = 8'h00, rdata, anc_data, bs_byte;
   logic       crc_bad, sync_missing, layer_bad, need_data, anc_push;
   logic       frame_start, frame_end, hdr_valid, bs_valid, en_q;
   logic       bass_q, play_q, irq_q;
   logic [2:0] rate_q;
   int         err_total = 0, check_count = 0;

   audio_decoder_ctrl_regs u_audio_decoder_ctrl_regs (
      .ref_clk(ref_clk), .arst_n(arst_n), .sfr_addr(sfr_addr),
      .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
      .sfr_rdata_q(rdata), .dec_irq_en(dec_ie), .global_irq_en(gie),
      .frame_start(frame_start), .frame_end(frame_end),
      .hdr_valid(hdr_valid), .hdr_version(hdr_version),
      .hdr_sampling(hdr_sampling), .crc_bad(crc_bad),
      .sync_missing(sync_missing), .layer_bad(layer_bad),
      .need_data(need_data), .anc_push(anc_push), .anc_byte(anc_byte),
      .anc_pop(anc_pop), .anc_data_q(anc_data), .bitstream_byte_q(bs_byte),
      .bitstream_valid_q(bs_valid), .decoder_enable_q(en_q),
      .bass_boost_enable_q(bass_q), .frame_play_q(play_q),
      .rate_sel_q(rate_q), .dec_irq_q(irq_q));
   dec_far_model u_dec_far_model (
      .ref_clk(ref_clk), .ev_req(ev_req), .crc_bad(crc_bad),
      .sync_missing(sync_missing), .layer_bad(layer_bad),
      .need_data(need_data), .anc_push(anc_push),
      .frame_start(frame_start), .frame_end(frame_end),
      .hdr_valid(hdr_valid));

   initial begin
      forever #50 ref_clk = ~ref_clk;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("FAIL %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic wt(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : wt
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge ref_clk);
      sfr_wr = 1'b0;
   endtask : wr
   // read, then compare the registered answer one cycle later
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      @(negedge ref_clk);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge ref_clk);
      sfr_rd = 1'b0;
      chk(rdata, exp);
   endtask : rdc
   // nonblocking so the model samples the old request at this edge
   task automatic fire(input logic [7:0] v);
      @(negedge ref_clk) ev_req <= v;
      @(negedge ref_clk) ev_req <= 8'h00;
      wt(3);
   endtask : fire

   task automatic t_regs;
      chk(8'(rate_q), 8'h04);
      rdc(8'hAA, 8'h3F);
      rdc(8'hC8, 8'h01);
      wr(8'hAA, 8'hC0);
      wt(1);
      chk({6'h00, en_q, bass_q}, 8'h03);
      rdc(8'hAA, 8'hC0);
      wr(8'hC8, 8'hFE);
      rdc(8'hC8, 8'h01);
      rdc(8'h00, 8'h00);
      wr(8'hAC, 8'hA5);
      chk({bs_byte[6:0], bs_valid}, 8'h4B);
      wt(1);
      chk(bs_byte, 8'hA5);
      chk(8'(bs_valid), 8'h00);
      rdc(8'hAC, 8'h00);
      $display("register test done");
   endtask : t_regs

   task automatic t_flags;
      wr(8'hAA, 8'h3F);
      fire(8'h01);
      rdc(8'hC8, 8'h01);
      for (int i = 0; i < 4; i++) begin
         wr(8'hAA, 8'hBF);
         fire(8'h01 << i);
         chk(8'(irq_q), 8'h00);
         wr(8'hAA, 8'hBF & ~(8'h01 << i));
         wt(3);
         chk(8'(irq_q), 8'h01);
         gie = 1'b0;
         wt(2);
         chk(8'(irq_q), 8'h00);
         gie = 1'b1;
         dec_ie = 1'b0;
         wt(2);
         chk(8'(irq_q), 8'h00);
         dec_ie = 1'b1;
         rdc(8'hC8, (8'h08 << i) | 8'h01);
         rdc(8'hC8, 8'h01);
         wt(2);
         chk(8'(irq_q), 8'h00);
      end
      $display("flag test done");
   endtask : t_flags

   task automatic t_anc;
      wr(8'hAA, 8'hBF);
      anc_byte = 8'h5A;
      fire(8'h10);
      rdc(8'hC8, 8'h81);
      rdc(8'hC8, 8'h81);
      chk(anc_data, 8'h5A);
      wr(8'hAA, 8'hAF);
      wt(3);
      chk(8'(irq_q), 8'h01);
      @(negedge ref_clk) anc_pop = 1'b1;
      @(negedge ref_clk) anc_pop = 1'b0;
      wt(2);
      rdc(8'hC8, 8'h01);
      chk(8'(irq_q), 8'h00);
      $display("ancillary test done");
   endtask : t_anc

   task automatic t_hdr;
      wr(8'hAA, 8'hBF);
      for (int k = 0; k < 8; k++) begin
         hdr_version = k[2];
         hdr_sampling = k[1:0];
         fire(8'h80);
         rdc(8'hC8, {5'h00, k[1:0], k[2]});
         chk(8'(rate_q), (k[1:0] == 2'h3) ? 8'h07 : 8'(k[2:0]));
      end
      $display("header test done");
   endtask : t_hdr

   task automatic t_frame;
      wr(8'hAA, 8'h9F);
      fire(8'h20);
      chk(8'(play_q), 8'h01);
      fire(8'h01);
      chk(8'(play_q), 8'h00);
      fire(8'h40);
      wr(8'hAA, 8'hBF);
      fire(8'h20);
      fire(8'h01);
      chk(8'(play_q), 8'h01);
      fire(8'h40);
      chk(8'(play_q), 8'h00);
      $display("frame test done");
   endtask : t_frame

   // mid-run reset after the crc flag and header were left set, with the frame state back at idle
   task automatic t_reset;
      @(negedge ref_clk) arst_n = 1'b0;
      wt(2);
      arst_n = 1'b1;
      chk({en_q, play_q, irq_q, bs_valid, 4'h0}, 8'h00);
      chk(8'(rate_q), 8'h04);
      rdc(8'hAA, 8'h3F);
      rdc(8'hC8, 8'h01);
      $display("reset test done");
   endtask : t_reset

   task automatic complete_run;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : complete_run

   // hang guard well beyond the longest sequence
   initial begin
      repeat (20000) @(posedge ref_clk);
      err_total++;
      $display("FAIL %0t watchdog expired", $time);
      complete_run();
   end

   initial begin
      wt(8);
      arst_n = 1'b1;
      t_regs();
      t_flags();
      t_anc();
      t_hdr();
      t_frame();
      t_reset();
      complete_run();
   end
endmodule : tb_top
`default_nettype wire
